// >>> src/snoop_filter_consts.svh
// Constants of the external snoop filter: transaction encodings and field positions.
`ifndef SNOOP_FILTER_CONSTS_SVH
`define SNOOP_FILTER_CONSTS_SVH

// ****************************************
// Read address channel snoop encodings (shareable domains)
// ****************************************
`define SF_RD_ONCE          4'h0
`define SF_RD_SHARED        4'h1
`define SF_RD_CLEAN         4'h2
`define SF_RD_NSD           4'h3
`define SF_RD_UNIQUE        4'h7
`define SF_RD_CLEAN_UNIQUE  4'hb
`define SF_RD_MAKE_UNIQUE   4'hc
`define SF_RD_CLEAN_SHARED  4'h8
`define SF_RD_CLEAN_INVAL   4'h9
`define SF_RD_MAKE_INVAL    4'hd

// ****************************************
// Write address channel snoop encodings
// ****************************************
`define SF_WR_UNIQUE        3'h0
`define SF_WR_LINE_UNIQUE   3'h1
`define SF_WR_CLEAN         3'h2
`define SF_WR_BACK          3'h3
`define SF_WR_EVICT_ONLY    3'h4
`define SF_WR_EVICT         3'h5

// ****************************************
// Domain codes, snoop response bit position and own snoop encoding
// ****************************************
`define SF_DOM_NONSH        2'h0
`define SF_DOM_SYSTEM       2'h3
`define SF_CR_ISSHARED_BIT  3
`define SF_AC_CLEAN_INVAL   4'h9

`endif

// >>> src/snoop_filter_pkg.sv
// Types shared by the external snoop filter design.
package snoop_filter_pkg;

	// Effect of an observed transaction on a tracked line.
	typedef enum logic [2:0] {
		ACT_NONE  = 3'h1,
		ACT_ALLOC = 3'h2,
		ACT_EVICT = 3'h4
	} line_act_e;

	// Snoop forwarding state machine.
	typedef enum logic [3:0] {
		SN_IDLE    = 4'h1,
		SN_FWD     = 4'h2,
		SN_WAIT_CR = 4'h4,
		SN_ANSWER  = 4'h8
	} snoop_state_e;

endpackage

// >>> src/sf_tag_store.sv
// Fully associative line tag store with lookup, insert, remove and victim select.
`timescale 1ns/10ps
`default_nettype none

module sf_tag_store #(
	parameter int ENTRIES = 16,
	parameter int TAG_W   = 26
) (
	input  wire logic                       clk_sys_i,
	input  wire logic                       rst_n_i,
	input  wire logic [TAG_W-1:0]           look_tag_i,
	output logic                            look_hit_o,
	input  wire logic                       ins_i,
	input  wire logic [TAG_W-1:0]           ins_tag_i,
	input  wire logic                       rem_i,
	input  wire logic [TAG_W-1:0]           rem_tag_i,
	output logic                            full_o,
	output logic [TAG_W-1:0]                victim_tag_o,
	output logic [$clog2(ENTRIES+1)-1:0]    count_o
);

	logic [ENTRIES-1:0]   valid_reg;
	logic [TAG_W-1:0]     tag_reg [ENTRIES];
	logic [ENTRIES-1:0]   look_hit_vec;
	logic [ENTRIES-1:0]   ins_hit_vec;
	logic [ENTRIES-1:0]   rem_hit_vec;
	logic [ENTRIES-1:0]   free_onehot;
	logic [ENTRIES-1:0]   free_vec;

	// Compare every entry against the three tags.
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++) begin : g_cmp
			assign look_hit_vec[g] = valid_reg[g] && (tag_reg[g] == look_tag_i);
			assign ins_hit_vec[g]  = valid_reg[g] && (tag_reg[g] == ins_tag_i);
			assign rem_hit_vec[g]  = valid_reg[g] && (tag_reg[g] == rem_tag_i);
		end
	endgenerate

	// Lowest free slot; a duplicate insert never takes a slot.
	assign free_vec    = ~valid_reg;
	assign free_onehot = free_vec & (~free_vec + ENTRIES'(1));
	assign look_hit_o  = |look_hit_vec;
	assign full_o      = &valid_reg;
	assign victim_tag_o = tag_reg[0];

	// Population count of valid entries.
	always_comb begin
		count_o = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			count_o = count_o + ($clog2(ENTRIES+1))'(valid_reg[i]);
		end
	end

	// Entries are cleared on reset; removal and insertion update the valid bits.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_reg <= '0; // R22
		end else begin
			for (int i = 0; i < ENTRIES; i++) begin
				if (rem_i && rem_hit_vec[i]) begin
					valid_reg[i] <= 1'b0;
				end else if (ins_i && !(|ins_hit_vec) && free_onehot[i]) begin
					valid_reg[i] <= 1'b1; // R16
				end
			end
		end
	end

	// Tag words need no reset; their valid bit guards them.
	always_ff @(posedge clk_sys_i) begin
		for (int i = 0; i < ENTRIES; i++) begin
			if (ins_i && !(|ins_hit_vec) && free_onehot[i]) begin
				tag_reg[i] <= ins_tag_i;
			end
		end
	end

endmodule

`default_nettype wire

// >>> src/external_snoop_filter.sv
// External snoop filter: tracks lines the master may hold and filters snoops to it.
//
// Summary of operation
// (R1) Watch every master transaction that may allocate.
// (R2) Watch evictions, write-backs and evicting snoops.
// (R3) Read/Clean/Make allocating types mark line allocated.
// (R4) Non-changing types leave tracked state alone.
// (R5) Invalidating, write-back and evict types deallocate.
// (R6) Master issues Evict when allocation differs.
// (R7) Error responses update tracking identically.
// (R8) Master repairs tracking after error-driven behaviour.
// (R9) Snoop channels and IsShared decide retention.
// (R10) Master returns accurate IsShared on snoops.
// (R11) Master never claims deallocation while holding.
// (R12) Master avoids overlapping allocate and evict.
// (R13) Overlap leaves line deallocated until clean allocate; the filter has no overlap check and updates on each address acceptance.
// (R14) Master resolves line state after overlaps.
// (R15) Non-snooping accesses are never tracked.
// (R16) Look up before insert; no duplicate entries.
// (R17) Store covers the whole cache geometry.
// (R18) Spare entries cover in-flight lines.
// (R19) On overflow, issue own CleanInvalid snoop.
// (R20) Master issues enough tracking transactions.
// (R21) Answer snoops to untracked lines directly.
// (R22) Reset clears every tracking entry.
// (R23) IsShared low removes the snooped line.
`timescale 1ns/10ps
`default_nettype none

`include "snoop_filter_consts.svh"

module external_snoop_filter #(
	parameter int ADDR_W     = 32,
	parameter int LINE_BYTES = 64,
	parameter int CACHE_LINES = 16,
	parameter int EXTRA_LINES = 2
) (
	input  wire logic               clk_sys_i,
	input  wire logic               nrst_i,
	// Master read address channel (observed).
	input  wire logic               ar_valid_i,
	input  wire logic               ar_ready_i,
	input  wire logic [ADDR_W-1:0]  ar_addr_i,
	input  wire logic [3:0]         ar_snoop_i,
	input  wire logic [1:0]         ar_domain_i,
	input  wire logic               ar_bar_i,
	// Master write address channel (observed).
	input  wire logic               aw_valid_i,
	input  wire logic               aw_ready_i,
	input  wire logic [ADDR_W-1:0]  aw_addr_i,
	input  wire logic [2:0]         aw_snoop_i,
	input  wire logic [1:0]         aw_domain_i,
	input  wire logic               aw_bar_i,
	// Snoop address from the interconnect.
	input  wire logic               ic_ac_valid_i,
	output logic                    ic_ac_ready_o,
	input  wire logic [ADDR_W-1:0]  ic_ac_addr_i,
	input  wire logic [3:0]         ic_ac_snoop_i,
	// Snoop response to the interconnect.
	output logic                    ic_cr_valid_o,
	input  wire logic               ic_cr_ready_i,
	output logic [4:0]              ic_cr_resp_o,
	// Snoop address to the master.
	output logic                    m_ac_valid_o,
	input  wire logic               m_ac_ready_i,
	output logic [ADDR_W-1:0]       m_ac_addr_o,
	output logic [3:0]              m_ac_snoop_o,
	// Snoop response from the master.
	input  wire logic               m_cr_valid_i,
	output logic                    m_cr_ready_o,
	input  wire logic [4:0]         m_cr_resp_i,
	// Status.
	output logic                    filtered_o,
	output logic                    overflow_o
);

	import snoop_filter_pkg::*;

	localparam int OFS_W   = $clog2(LINE_BYTES);
	localparam int TAG_W   = ADDR_W - OFS_W;
	localparam int ENTRIES = CACHE_LINES + EXTRA_LINES; // R17 R18

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_reg;
	logic rst_n_reg;

	// Release the reset through two flip-flops.
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// ****************************************
	// Classification of master transactions
	// ****************************************
	line_act_e  ar_act;
	line_act_e  aw_act;
	wire        ar_fire  = ar_valid_i && ar_ready_i;
	wire        aw_fire  = aw_valid_i && aw_ready_i;
	wire        ar_shar  = (ar_domain_i != `SF_DOM_NONSH) && (ar_domain_i != `SF_DOM_SYSTEM);
	wire        aw_shar  = (aw_domain_i != `SF_DOM_NONSH) && (aw_domain_i != `SF_DOM_SYSTEM);

	// Read channel types; barriers and system-domain reads never touch tracking; non-shareable CleanInvalid/MakeInvalid remove the line.
	always_comb begin
		ar_act = ACT_NONE;
		if (ar_fire && !ar_bar_i && ar_shar) begin // R1 R15
			case (ar_snoop_i)
				`SF_RD_SHARED, `SF_RD_CLEAN, `SF_RD_NSD, `SF_RD_UNIQUE,
				`SF_RD_CLEAN_UNIQUE, `SF_RD_MAKE_UNIQUE: ar_act = ACT_ALLOC; // R3
				`SF_RD_CLEAN_INVAL, `SF_RD_MAKE_INVAL: ar_act = ACT_EVICT; // R5
				default: ar_act = ACT_NONE; // R4
			endcase
		end else if (ar_fire && !ar_bar_i && (ar_domain_i != `SF_DOM_SYSTEM)
			&& (ar_snoop_i == `SF_RD_CLEAN_INVAL || ar_snoop_i == `SF_RD_MAKE_INVAL)) begin
			ar_act = ACT_EVICT; // R5
		end
	end

	// Write channel types.
	always_comb begin
		aw_act = ACT_NONE;
		if (aw_fire && !aw_bar_i && aw_shar) begin // R2 R15
			case (aw_snoop_i)
				`SF_WR_BACK, `SF_WR_EVICT_ONLY, `SF_WR_EVICT: aw_act = ACT_EVICT; // R5
				default: aw_act = ACT_NONE; // R4
			endcase
		end
	end

	// ****************************************
	// Snoop handling state machine
	// ****************************************
	snoop_state_e             sn_state_reg;
	snoop_state_e             sn_state_next;
	logic [ADDR_W-1:0]        sn_addr_reg;
	logic [3:0]               sn_snoop_reg;
	logic                     sn_own_reg;
	logic [4:0]               resp_reg;
	logic                     filtered_reg;
	logic                     overflow_reg;

	logic                     look_hit;
	logic                     store_full;
	logic [TAG_W-1:0]         victim_tag;

	// A snoop waits while a read allocates, so the single look-up port serves the insert.
	wire  rd_alloc  = (ar_act == ACT_ALLOC);
	wire  ac_take   = ic_ac_ready_o && ic_ac_valid_i;
	wire  need_room = rd_alloc && store_full && !look_hit;
	wire  own_start = (sn_state_reg == SN_IDLE) && !ic_ac_valid_i && overflow_reg;
	wire  cr_take   = (sn_state_reg == SN_WAIT_CR) && m_cr_valid_i;
	wire  cr_evicts = cr_take && !m_cr_resp_i[`SF_CR_ISSHARED_BIT]; // R9 R23

	// The tag look-up port serves the snoop address when one is taken, else the read.
	wire [TAG_W-1:0] look_tag = ac_take ? ic_ac_addr_i[ADDR_W-1:OFS_W]
		: ar_addr_i[ADDR_W-1:OFS_W];
	wire             snoop_hit = look_hit;

	assign ic_ac_ready_o = (sn_state_reg == SN_IDLE) && !rd_alloc;
	assign m_ac_valid_o  = (sn_state_reg == SN_FWD);
	assign m_cr_ready_o  = (sn_state_reg == SN_WAIT_CR);
	assign ic_cr_valid_o = (sn_state_reg == SN_ANSWER);
	assign m_ac_addr_o   = sn_addr_reg;
	assign m_ac_snoop_o  = sn_snoop_reg;
	assign ic_cr_resp_o  = resp_reg;
	assign filtered_o    = filtered_reg;
	assign overflow_o    = overflow_reg;

	// Next state: untracked snoops are answered at once, tracked ones go to the master.
	always_comb begin
		sn_state_next = sn_state_reg;
		case (sn_state_reg)
			SN_IDLE: begin
				if (ac_take) begin
					sn_state_next = snoop_hit ? SN_FWD : SN_ANSWER; // R21
				end else if (own_start) begin
					sn_state_next = SN_FWD; // R19
				end
			end
			SN_FWD: begin
				if (m_ac_ready_i) begin
					sn_state_next = SN_WAIT_CR;
				end
			end
			SN_WAIT_CR: begin
				if (m_cr_valid_i) begin
					sn_state_next = sn_own_reg ? SN_IDLE : SN_ANSWER;
				end
			end
			SN_ANSWER: begin
				if (ic_cr_ready_i) begin
					sn_state_next = SN_IDLE;
				end
			end
			default: sn_state_next = SN_IDLE;
		endcase
	end

	// Snoop state, captured snoop and response.
	always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			sn_state_reg <= SN_IDLE;
			sn_addr_reg  <= '0;
			sn_snoop_reg <= '0;
			sn_own_reg   <= 1'b0;
			resp_reg     <= '0;
			filtered_reg <= 1'b0;
		end else begin
			sn_state_reg <= sn_state_next;
			filtered_reg <= ac_take && !snoop_hit;
			if (ac_take) begin
				sn_addr_reg  <= ic_ac_addr_i;
				sn_snoop_reg <= ic_ac_snoop_i;
				sn_own_reg   <= 1'b0;
				resp_reg     <= '0; // R21
			end else if (own_start) begin
				sn_addr_reg  <= {victim_tag, {OFS_W{1'b0}}};
				sn_snoop_reg <= `SF_AC_CLEAN_INVAL; // R19
				sn_own_reg   <= 1'b1;
			end
			if (cr_take) begin
				resp_reg <= m_cr_resp_i;
			end
		end
	end

	// Overflow request: set by a new line finding the store full, cleared once the
	// evicting snoop is launched. The set wins over the clear.
	always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			overflow_reg <= 1'b0;
		end else if (need_room) begin
			overflow_reg <= 1'b1; // R19
		end else if (own_start) begin
			overflow_reg <= 1'b0;
		end
	end

	// ****************************************
	// Tracking store
	// ****************************************
	// Inserts happen on address acceptance, so error responses change nothing (R7).
	// One line is removed per cycle: a snoop leaving it unshared, else a write-channel eviction, else a read-channel one.
	wire             rem_ar  = (ar_act == ACT_EVICT);
	wire             rem_aw  = (aw_act == ACT_EVICT);
	wire             do_rem  = rem_ar || rem_aw || cr_evicts; // R2
	wire [TAG_W-1:0] rem_tag = cr_evicts ? sn_addr_reg[ADDR_W-1:OFS_W]
		: (rem_aw ? aw_addr_i[ADDR_W-1:OFS_W] : ar_addr_i[ADDR_W-1:OFS_W]);
	// The read insert owns the look-up port in its cycle, since snoops are held off;
	// the store also refuses a second entry for a line it already holds.
	wire             do_ins  = (ar_act == ACT_ALLOC); // R7 R16

	sf_tag_store #(
		.ENTRIES (ENTRIES),
		.TAG_W   (TAG_W)
	) u_store (
		.clk_sys_i    (clk_sys_i),
		.rst_n_i      (rst_n_reg),
		.look_tag_i   (look_tag),
		.look_hit_o   (look_hit),
		.ins_i        (do_ins),
		.ins_tag_i    (ar_addr_i[ADDR_W-1:OFS_W]),
		.rem_i        (do_rem),
		.rem_tag_i    (rem_tag),
		.full_o       (store_full),
		.victim_tag_o (victim_tag),
		.count_o      ()
	);

endmodule

`default_nettype wire

// >>> verif/external_snoop_filter_asserts.sv
// Concurrent checks on the snoop channels of the external snoop filter.
`timescale 1ns/10ps
`default_nettype none
`include "snoop_filter_consts.svh"

module external_snoop_filter_asserts #(
	parameter int ADDR_W = 32
) (
	input  wire logic              clk_sys_i,
	input  wire logic              nrst_i,
	input  wire logic              ic_ac_valid_i,
	input  wire logic              ic_ac_ready_o,
	input  wire logic [ADDR_W-1:0] ic_ac_addr_i,
	input  wire logic              ic_cr_valid_o,
	input  wire logic [4:0]        ic_cr_resp_o,
	input  wire logic              m_ac_valid_o,
	input  wire logic              m_ac_ready_i,
	input  wire logic [ADDR_W-1:0] m_ac_addr_o,
	input  wire logic [3:0]        m_ac_snoop_o,
	input  wire logic              m_cr_valid_i,
	input  wire logic              m_cr_ready_o,
	input  wire logic [4:0]        m_cr_resp_i,
	input  wire logic              filtered_o,
	input  wire logic              overflow_o
);
	// All checks run on the system clock and rest while reset is low.
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	AST_SNOOP_ANSWER: assert property (ic_ac_valid_i && ic_ac_ready_o |=>
		ic_cr_valid_o ^ m_ac_valid_o) else $error("taken snoop got no single answer");
	AST_FWD_ADDR: assert property (ic_ac_valid_i && ic_ac_ready_o ##1 m_ac_valid_o |->
		m_ac_addr_o == $past(ic_ac_addr_i)) else $error("forwarded snoop address wrong");
	AST_DIRECT_RESP: assert property (ic_ac_valid_i && ic_ac_ready_o ##1 ic_cr_valid_o |->
		ic_cr_resp_o == 5'h00) else $error("direct snoop answer not zero");
	AST_RESP_PASS: assert property (m_cr_valid_i && m_cr_ready_o ##1 ic_cr_valid_o |->
		ic_cr_resp_o == $past(m_cr_resp_i)) else $error("master response not passed on");
	AST_ONE_SNOOP: assert property (m_ac_valid_o || m_cr_ready_o || ic_cr_valid_o |->
		!ic_ac_ready_o) else $error("new snoop accepted while one is open");
	AST_AC_HOLD: assert property (m_ac_valid_o && !m_ac_ready_i |=> m_ac_valid_o &&
		$stable(m_ac_addr_o) && $stable(m_ac_snoop_o)) else $error("master snoop dropped");
	AST_CR_WAIT: assert property (m_ac_valid_o && m_ac_ready_i |=> m_cr_ready_o)
		else $error("no wait for master response");
	AST_OWN_SNOOP: assert property (overflow_o && ic_ac_ready_o && !ic_ac_valid_i |=>
		m_ac_valid_o && m_ac_snoop_o == `SF_AC_CLEAN_INVAL) else $error("no eviction snoop");
	AST_FILT_QUIET: assert property (filtered_o |-> !m_ac_valid_o && !m_cr_ready_o)
		else $error("filtered snoop reached master");
endmodule
`default_nettype wire

// >>> verif/sf_master_model.sv
// Behavioural cached master that answers the snoop filter's snoops.
`timescale 1ns/10ps
`default_nettype none

module sf_master_model (
	input  wire logic        clk_sys_i,
	input  wire logic        m_ac_valid_i,
	input  wire logic [31:0] m_ac_addr_i,
	input  wire logic [3:0]  m_ac_snoop_i,
	output logic             m_ac_ready_o,
	output logic             m_cr_valid_o,
	input  wire logic        m_cr_ready_i,
	output logic [4:0]       m_cr_resp_o,
	input  wire logic        share_i,
	input  wire logic [3:0]  dly_i,
	output logic [31:0]      last_addr_o,
	output logic [3:0]       last_snoop_o,
	output logic [7:0]       n_snoop_o
);
	// Accept each snoop after a set stall, then report whether the line stays held.
	initial begin
		m_ac_ready_o = 1'b0;
		m_cr_valid_o = 1'b0;
		m_cr_resp_o = 5'h1f;
		n_snoop_o = 8'h00;
		forever begin
			@(negedge clk_sys_i);
			if (m_ac_valid_i) begin
				last_addr_o = m_ac_addr_i;
				last_snoop_o = m_ac_snoop_i;
				repeat (dly_i) @(posedge clk_sys_i);
				#1 m_ac_ready_o = 1'b1;
				@(posedge clk_sys_i);
				n_snoop_o = n_snoop_o + 8'h01;
				#1 m_ac_ready_o = 1'b0;
				m_cr_valid_o = 1'b1;
				m_cr_resp_o = {1'b0, share_i, 3'h0};
				do @(negedge clk_sys_i); while (!m_cr_ready_i);
				@(posedge clk_sys_i);
				#1 m_cr_valid_o = 1'b0;
				m_cr_resp_o = ~m_cr_resp_o;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/external_snoop_filter_tb.sv
// Self-checking bench for the external snoop filter.
`timescale 1ns/10ps
`default_nettype none
`include "snoop_filter_consts.svh"

module external_snoop_filter_tb;
	logic clk_sys_i = 0, nrst_i = 0, ar_valid_i = 0, ar_ready_i = 1, aw_valid_i = 0;
	logic aw_ready_i = 1, ic_ac_valid_i = 0, m_ac_ready_i, m_cr_valid_i, share_i = 1;
	logic [31:0] ar_addr_i = 0, aw_addr_i = 0, ic_ac_addr_i = 0, m_ac_addr_o, last_addr;
	logic [3:0] ar_snoop_i = 0, m_ac_snoop_o, last_snoop, dly_i = 0;
	logic [2:0] aw_snoop_i = 0;
	logic [1:0] ar_domain_i = 0, aw_domain_i = 0;
	logic [4:0] ic_cr_resp_o, m_cr_resp_i;
	logic [7:0] n_snoop;
	logic ic_ac_ready_o, ic_cr_valid_o, m_ac_valid_o, m_cr_ready_o, filtered_o, overflow_o;
	int n_mismatch = 0, tests_run = 0, cycles = 0;
	// Allocating, evicting and neutral types; bit 4 picks the write channel.
	logic [4:0] alc [6] = '{5'h1, 5'h2, 5'h3, 5'h7, 5'hb, 5'hc};
	logic [4:0] evc [5] = '{5'h09, 5'h0d, 5'h13, 5'h14, 5'h15};
	logic [4:0] kep [5] = '{5'h00, 5'h08, 5'h10, 5'h11, 5'h12};

	external_snoop_filter #(.ADDR_W(32)) u_dut (.clk_sys_i, .nrst_i, .ar_valid_i, .ar_ready_i,
		.ar_addr_i, .ar_snoop_i, .ar_domain_i, .ar_bar_i(1'b0), .aw_valid_i, .aw_ready_i,
		.aw_addr_i, .aw_snoop_i, .aw_domain_i, .aw_bar_i(1'b0), .ic_ac_valid_i,
		.ic_ac_ready_o, .ic_ac_addr_i, .ic_ac_snoop_i(4'h1), .ic_cr_valid_o,
		.ic_cr_ready_i(1'b1), .ic_cr_resp_o, .m_ac_valid_o, .m_ac_ready_i, .m_ac_addr_o,
		.m_ac_snoop_o, .m_cr_valid_i, .m_cr_ready_o, .m_cr_resp_i, .filtered_o, .overflow_o);
	sf_master_model u_mst (.clk_sys_i, .m_ac_valid_i(m_ac_valid_o), .m_ac_addr_i(m_ac_addr_o),
		.m_ac_snoop_i(m_ac_snoop_o), .m_ac_ready_o(m_ac_ready_i), .m_cr_valid_o(m_cr_valid_i),
		.m_cr_ready_i(m_cr_ready_o), .m_cr_resp_o(m_cr_resp_i), .share_i, .dly_i,
		.last_addr_o(last_addr), .last_snoop_o(last_snoop), .n_snoop_o(n_snoop));

	// Clock and a cycle ceiling that cuts a hang short.
	always #2 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic do_reset();
		@(negedge clk_sys_i);
		nrst_i = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
	endtask

	// One master request on the read or write address channel, ready held off a cycle.
	task automatic obs(input logic [4:0] c, input logic [1:0] dom, input logic [31:0] a);
		@(negedge clk_sys_i);
		{ar_addr_i, aw_addr_i, ar_domain_i, aw_domain_i} = {a, a, dom, dom};
		{ar_snoop_i, aw_snoop_i} = {c[3:0], c[2:0]};
		{ar_valid_i, aw_valid_i, ar_ready_i, aw_ready_i} = {!c[4], c[4], 2'b00};
		@(negedge clk_sys_i);
		{ar_ready_i, aw_ready_i} = 2'b11;
		@(negedge clk_sys_i);
		{ar_valid_i, aw_valid_i, ar_addr_i, aw_addr_i} = {2'b00, ~a, ~a};
	endtask

	// One interconnect snoop; checks the answer and whether the master saw it.
	task automatic snp(input logic [31:0] a, input logic fwd, sh, input logic [3:0] d);
		int k;
		logic [7:0] n0;
		{share_i, dly_i, n0} = {sh, d, n_snoop};
		@(negedge clk_sys_i);
		{ic_ac_valid_i, ic_ac_addr_i} = {1'b1, a};
		for (k = 0; k < 200 && !ic_ac_ready_o; k++) @(negedge clk_sys_i);
		@(negedge clk_sys_i);
		{ic_ac_valid_i, ic_ac_addr_i} = {1'b0, ~a};
		for (k = 0; k < 200 && !ic_cr_valid_o; k++) @(negedge clk_sys_i);
		chk("snoop resp", {27'h0, ic_cr_resp_o}, fwd ? {28'h0, sh, 3'h0} : 32'h0);
		chk("snoops passed", {24'h0, n_snoop - n0}, {31'h0, fwd});
		chk("filtered", {31'h0, filtered_o}, {31'h0, !fwd});
		if (fwd) chk("snoop addr", last_addr, a);
	endtask

	task automatic t_reset();
		obs(alc[0], 2'h1, 32'h100);
		snp(32'h100, 1'b1, 1'b1, 4'h0);
		do_reset();
		snp(32'h100, 1'b0, 1'b1, 4'h0);
	endtask

	task automatic t_alloc();
		for (int i = 0; i < 6; i++) begin
			obs(alc[i], 2'h1, 32'h1000 + i * 64);
			snp(32'h1000 + i * 64, 1'b1, 1'b1, i[3:0]);
			snp(32'h1000 + i * 64, 1'b1, 1'b0, 4'h0);
			snp(32'h1000 + i * 64, 1'b0, 1'b0, 4'h0);
		end
	endtask

	task automatic t_evict();
		for (int i = 0; i < 5; i++) begin
			obs(alc[0], 2'h2, 32'h2000 + i * 64);
			obs(evc[i], 2'h2, 32'h2000 + i * 64);
			snp(32'h2000 + i * 64, 1'b0, 1'b1, 4'h0);
		end
	endtask

	task automatic t_keep();
		for (int i = 0; i < 5; i++) begin
			obs(kep[i], 2'h1, 32'h3000 + i * 64);
			snp(32'h3000 + i * 64, 1'b0, 1'b1, 4'h0);
			obs(alc[1], 2'h1, 32'h3800 + i * 64);
			obs(kep[i], 2'h1, 32'h3800 + i * 64);
			snp(32'h3800 + i * 64, 1'b1, 1'b1, 4'h2);
		end
	endtask

	task automatic t_nonshare();
		obs(alc[0], 2'h0, 32'h4000);
		obs(alc[3], 2'h3, 32'h4040);
		snp(32'h4000, 1'b0, 1'b1, 4'h0);
		snp(32'h4040, 1'b0, 1'b1, 4'h0);
	endtask

	task automatic t_overflow();
		logic [7:0] n0;
		do_reset();
		{share_i, dly_i, n0} = {1'b0, 4'h4, n_snoop};
		repeat (20) obs(alc[1], 2'h1, 32'h8000);
		for (int i = 1; i < 18; i++) obs(alc[3], 2'h1, 32'h8000 + i * 64);
		chk("overflow at 18 lines", {31'h0, overflow_o}, 32'h0);
		obs(alc[3], 2'h1, 32'h8000 + 18 * 64);
		chk("overflow set", {31'h0, overflow_o}, 32'h1);
		for (int k = 0; k < 100 && n_snoop == n0; k++) @(negedge clk_sys_i);
		chk("eviction snoop", {28'h0, last_snoop}, {28'h0, `SF_AC_CLEAN_INVAL});
		chk("victim line", last_addr, 32'h8000);
		for (int k = 0; k < 100 && overflow_o; k++) @(negedge clk_sys_i);
		snp(last_addr, 1'b0, 1'b0, 4'h0);
	endtask

	initial begin
		do_reset();
		t_reset();
		t_alloc();
		t_evict();
		t_keep();
		t_nonshare();
		t_overflow();
		close_out();
	end
endmodule

bind external_snoop_filter external_snoop_filter_asserts #(.ADDR_W(ADDR_W)) u_chk (
	.clk_sys_i, .nrst_i, .ic_ac_valid_i, .ic_ac_ready_o, .ic_ac_addr_i, .ic_cr_valid_o,
	.ic_cr_resp_o, .m_ac_valid_o, .m_ac_ready_i, .m_ac_addr_o, .m_ac_snoop_o, .m_cr_valid_i,
	.m_cr_ready_o, .m_cr_resp_i, .filtered_o, .overflow_o);
`default_nettype wire
